// *** rtl/rcf_host.sv ***
// rcf_host: host end, parses response frames, APB register view.
// assumes: link driven by rcf_dev on the same clock.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module rcf_host (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// request out to the module
	output logic req_valid,
	output logic [7:0] req_frame_id,
	output logic [63:0] req_dst_addr,
	output logic [7:0] req_options,
	output logic [15:0] req_cmd,
	output logic [31:0] req_param,
	// serial link
	rcf_link_if.host link
);
	typedef enum logic [2:0] {H_DELIM, H_LEN_HI, H_LEN_LO, H_BODY,
		H_CSUM} rcf_hstate_e;
	rcf_hstate_e st_r;
	logic [15:0] len_r;
	logic [15:0] cnt_r;
	logic [7:0] sum_r;
	logic [2:0] stat_r;
	logic [2:0] mask_r;
	logic [2:0] ev_w;
	logic [7:0] info_id_r;
	logic [7:0] info_status_r;
	logic [15:0] info_cmd_r;
	logic [31:0] info_data_r;
	logic [63:0] info_src_r;
	logic [31:0] ctrl_r;
	logic wr_w;
	logic rd_w;
	logic good_w;

	assign wr_w = psel && penable && pwrite && pready;
	assign rd_w = psel && !penable;
	assign good_w = (st_r == H_CSUM) && link.valid
		&& (rcf_pkg::csum_of(sum_r) == link.data);
	// events: good frame, bad checksum, frame with zero id
	assign ev_w[0] = good_w;
	assign ev_w[1] = (st_r == H_CSUM) && link.valid && !good_w;
	assign ev_w[2] = good_w && info_id_r == 8'h00;

	always_ff @(posedge core_clk) begin
		if (sys_rst) link.ready <= 1'b0;
		else link.ready <= 1'b1;
	end

	// frame parser, re-arms after each frame
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= H_DELIM;
			len_r <= 16'h0;
			cnt_r <= 16'h0;
			sum_r <= 8'h00;
			info_id_r <= 8'h00;
			info_status_r <= 8'h00;
			info_cmd_r <= 16'h0;
			info_data_r <= 32'h0;
			info_src_r <= 64'h0;
		end else if (link.valid && link.ready) begin
			unique case (st_r)
				H_DELIM: if (link.data == rcf_pkg::DELIM) st_r <= H_LEN_HI;
				H_LEN_HI: begin
					len_r[15:8] <= link.data;
					st_r <= H_LEN_LO;
				end
				H_LEN_LO: begin
					len_r[7:0] <= link.data;
					cnt_r <= 16'h0;
					sum_r <= 8'h00;
					info_data_r <= 32'h0;
					st_r <= H_BODY;
				end
				H_BODY: begin
					sum_r <= sum_r + link.data;
					// reserved 13-14 deliberately ignored
					if (cnt_r == 16'd1) info_id_r <= link.data;
					if (cnt_r >= 16'd2 && cnt_r <= 16'd9)
						info_src_r <= {info_src_r[55:0], link.data};
					if (cnt_r == 16'd12 || cnt_r == 16'd13)
						info_cmd_r <= {info_cmd_r[7:0], link.data};
					if (cnt_r == 16'd14) info_status_r <= link.data;
					if (cnt_r >= 16'd15)
						info_data_r <= {info_data_r[23:0], link.data};
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r + 16'h0001 == len_r) st_r <= H_CSUM;
				end
				H_CSUM: st_r <= H_DELIM;
				default: st_r <= H_DELIM;
			endcase
		end
	end

	// sticky status, set wins over write-one clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) stat_r <= rcf_pkg::IRQ_RESET;
		else if (wr_w && paddr == rcf_pkg::REG_STAT)
			stat_r <= (stat_r & ~pwdata[2:0]) | ev_w;
		else stat_r <= stat_r | ev_w;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) irq <= 1'b0;
		// a set mask bit hides its status bit
		else irq <= |(stat_r & ~mask_r);
	end

	// control and request registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_r <= rcf_pkg::CTRL_RST;
			mask_r <= rcf_pkg::IRQ_RESET;
			req_dst_addr <= 64'h0;
			req_cmd <= 16'h0;
			req_param <= 32'h0;
			req_valid <= 1'b0;
			req_frame_id <= 8'h00;
			req_options <= 8'h00;
		end else begin
			req_valid <= 1'b0;
			if (wr_w) begin
				unique case (paddr)
					rcf_pkg::REG_MASK: mask_r <= pwdata[2:0];
					rcf_pkg::REG_ADDR_HI: req_dst_addr[63:32] <= pwdata;
					rcf_pkg::REG_ADDR_LO: req_dst_addr[31:0] <= pwdata;
					rcf_pkg::REG_CMD: req_cmd <= pwdata[15:0];
					rcf_pkg::REG_PARAM: req_param <= pwdata;
					rcf_pkg::REG_CTRL: begin
						ctrl_r <= pwdata;
						req_frame_id <= pwdata[15:8];
						req_options <= pwdata[7:0];
						// broadcast destination refused
						req_valid <= pwdata[16]
							&& req_dst_addr != 64'h0000_0000_0000_FFFF;
					end
					default: ;
				endcase
			end
		end
	end

	// apb: no wait states, read data latched in setup
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > rcf_pkg::REG_RX_SRC_LO;
			if (rd_w) begin
				unique case (paddr)
					rcf_pkg::REG_CTRL: prdata <= ctrl_r & 32'h0000_FFFF;
					rcf_pkg::REG_STAT: prdata <= {29'h0, stat_r};
					rcf_pkg::REG_MASK: prdata <= {29'h0, mask_r};
					rcf_pkg::REG_ADDR_HI: prdata <= req_dst_addr[63:32];
					rcf_pkg::REG_ADDR_LO: prdata <= req_dst_addr[31:0];
					rcf_pkg::REG_CMD: prdata <= {16'h0, req_cmd};
					rcf_pkg::REG_PARAM: prdata <= req_param;
					rcf_pkg::REG_RX_INFO:
						prdata <= {info_id_r, info_status_r, info_cmd_r};
					rcf_pkg::REG_RX_DATA: prdata <= info_data_r;
					rcf_pkg::REG_RX_SRC_HI: prdata <= info_src_r[63:32];
					rcf_pkg::REG_RX_SRC_LO: prdata <= info_src_r[31:0];
					default: prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule : rcf_host

// *** rtl/rcf_pkg.sv ***
// rcf_pkg: constants shared by both ends of the remote response framer.
// assumes: byte-wide serial stream between module end and host end.
package rcf_pkg;
	localparam logic [7:0] DELIM = 8'h7E;
	localparam logic [7:0] TYPE_RESP = 8'h97;
	localparam logic [7:0] CSUM_BASE = 8'hFF;
	localparam logic [7:0] RSV_HI = 8'hFF;
	localparam logic [7:0] RSV_LO = 8'hFE;
	localparam logic [3:0] ST_OK = 4'h0;
	localparam logic [3:0] ST_ERROR = 4'h1;
	localparam logic [3:0] ST_BAD_CMD = 4'h2;
	localparam logic [3:0] ST_BAD_PARAM = 4'h3;
	localparam logic [7:0] FLAG_RSSI_BAD = 8'h40;
	localparam logic [7:0] FLAG_REMOTE = 8'h80;
	localparam int OFS_TYPE = 3;
	localparam int OFS_ID = 4;
	localparam int OFS_ADDR = 5;
	localparam int OFS_RSV = 13;
	localparam int OFS_CMD = 15;
	localparam int OFS_STATUS = 17;
	localparam int OFS_DATA = 18;
	// fixed bytes from type through status
	localparam logic [15:0] HDR_LEN = 16'h000F;
	localparam int MAX_DATA = 8;
	// host register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_ADDR_HI = 8'h0C;
	localparam logic [7:0] REG_ADDR_LO = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	localparam logic [7:0] REG_PARAM = 8'h18;
	localparam logic [7:0] REG_RX_INFO = 8'h1C;
	localparam logic [7:0] REG_RX_DATA = 8'h20;
	localparam logic [7:0] REG_RX_SRC_HI = 8'h24;
	localparam logic [7:0] REG_RX_SRC_LO = 8'h28;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	// request option bit that applies changes at once
	localparam int OPT_APPLY_BIT = 1;
	localparam logic [15:0] CMD_APPLY = 16'h4143;
	localparam logic [15:0] CMD_SAVE = 16'h5752;
	localparam logic [15:0] CMD_SOFT_RESET = 16'h4652;
	localparam logic [15:0] CMD_SERIAL_RATE = 16'h4244;
	localparam logic [15:0] CMD_NODE_DISC = 16'h4E44;
	localparam logic [15:0] CMD_SERIAL_LOW = 16'h534C;
	localparam logic [31:0] SERIAL_RATE_RST = 32'h0000_0003;

	function automatic logic [7:0] csum_of(input logic [7:0] sum);
		return CSUM_BASE - sum;
	endfunction : csum_of
endpackage : rcf_pkg

// *** rtl/rcf_link_if.sv ***
// rcf_link_if: byte stream from module end to host end.
// assumes: both ends share core_clk; valid held until ready.
`timescale 1ns/1ps
interface rcf_link_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport dev (output data, output valid, input ready);
	modport host (input data, input valid, output ready);
endinterface : rcf_link_if

// *** rtl/rcf_dev.sv ***
// rcf_dev: module end, frames remote command replies onto the serial link.
// assumes: radio side presents one decoded reply per rx_valid pulse.
`timescale 1ns/1ps
module rcf_dev #(
	parameter int MAX_DATA = rcf_pkg::MAX_DATA
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// radio reply
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic rx_reachable,
	input wire logic [7:0] rx_frame_id,
	input wire logic [63:0] rx_src_addr,
	input wire logic [15:0] rx_cmd,
	input wire logic [3:0] rx_status,
	input wire logic rx_rssi_bad,
	input wire logic [3:0] rx_data_len,
	input wire logic [8*MAX_DATA-1:0] rx_data,
	// local view of a remote node's settings
	input wire logic cfg_we,
	input wire logic [15:0] cfg_cmd,
	input wire logic [31:0] cfg_value,
	input wire logic cfg_apply_opt,
	output logic [31:0] serial_rate_setting,
	output logic [31:0] pending_rate,
	// serial link
	rcf_link_if.dev link
);
	typedef enum logic [1:0] {IDLE, SEND, CSUM} rcf_state_e;
	rcf_state_e state_r;
	logic [7:0] idx_r;
	logic [7:0] last_r;
	logic [7:0] sum_r;
	logic [7:0] id_r;
	logic [63:0] addr_r;
	logic [15:0] cmd_r;
	logic [7:0] status_r;
	logic [8*MAX_DATA-1:0] data_r;
	logic [7:0] byte_cur;
	logic saved_r;
	logic [15:0] len_w;

	assign len_w = rcf_pkg::HDR_LEN + 16'(last_r) - 16'(rcf_pkg::OFS_DATA)
		+ 16'h0001;

	// idle only takes new replies; frames never interleave
	always_ff @(posedge core_clk) begin
		if (sys_rst) rx_ready <= 1'b0;
		else rx_ready <= (state_r == IDLE) && !rx_ready;
	end

	// byte mux over frame offsets
	always_comb begin
		byte_cur = 8'h00;
		unique case (idx_r)
			8'd0: byte_cur = rcf_pkg::DELIM;
			8'd1: byte_cur = len_w[15:8];
			8'd2: byte_cur = len_w[7:0];
			8'd3: byte_cur = rcf_pkg::TYPE_RESP;
			8'd4: byte_cur = id_r;
			8'd13: byte_cur = rcf_pkg::RSV_HI;
			8'd14: byte_cur = rcf_pkg::RSV_LO;
			8'd15: byte_cur = cmd_r[15:8];
			8'd16: byte_cur = cmd_r[7:0];
			8'd17: byte_cur = status_r;
			default: begin
				if (idx_r >= 8'd5 && idx_r <= 8'd12)
					byte_cur = addr_r[8'd63 - 8'(8 * (idx_r - 8'd5)) -: 8];
				else if (idx_r >= 8'd18)
					byte_cur = data_r[8*MAX_DATA-1 - 8 * (idx_r - 8'd18) -: 8];
			end
		endcase
	end

	// framing sequence
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= IDLE;
			idx_r <= 8'h00;
			last_r <= 8'h00;
			sum_r <= 8'h00;
			id_r <= 8'h00;
			addr_r <= 64'h0;
			cmd_r <= 16'h0;
			status_r <= 8'h00;
			data_r <= '0;
			link.valid <= 1'b0;
			link.data <= 8'h00;
		end else begin
			unique case (state_r)
				IDLE: begin
					link.valid <= 1'b0;
					// each reachable reply with a nonzero id is framed alone, so bursts give many frames
					if (rx_valid && rx_ready && rx_reachable
						&& rx_frame_id != 8'h00) begin
						id_r <= rx_frame_id;
						addr_r <= rx_src_addr;
						cmd_r <= rx_cmd;
						status_r <= rcf_pkg::FLAG_REMOTE
							| (rx_rssi_bad ? rcf_pkg::FLAG_RSSI_BAD : 8'h00)
							| {4'h0, rx_status};
						data_r <= rx_data;
						last_r <= 8'(rcf_pkg::OFS_DATA) + 8'(rx_data_len)
							- 8'h01;
						idx_r <= 8'h00;
						sum_r <= 8'h00;
						state_r <= SEND;
					end
				end
				SEND: begin
					if (!link.valid || link.ready) begin
						link.valid <= 1'b1;
						link.data <= byte_cur;
						if (idx_r >= 8'd3) sum_r <= sum_r + byte_cur;
						if (idx_r == last_r) state_r <= CSUM;
						idx_r <= idx_r + 8'h01;
					end
				end
				CSUM: begin
					if (link.ready) begin
						if (idx_r != 8'hFF) begin
							link.data <= rcf_pkg::csum_of(sum_r);
							idx_r <= 8'hFF;
						end else begin
							link.valid <= 1'b0;
							state_r <= IDLE;
						end
					end
				end
				default: state_r <= IDLE;
			endcase
		end
	end

	// pending vs active remote settings
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			serial_rate_setting <= rcf_pkg::SERIAL_RATE_RST;
			pending_rate <= rcf_pkg::SERIAL_RATE_RST;
			saved_r <= 1'b0;
		end else if (cfg_we) begin
			if (cfg_cmd == rcf_pkg::CMD_SERIAL_RATE) begin
				pending_rate <= cfg_value;
				if (cfg_apply_opt) serial_rate_setting <= cfg_value;
			end else if (cfg_cmd == rcf_pkg::CMD_APPLY) begin
				serial_rate_setting <= pending_rate;
			end else if (cfg_cmd == rcf_pkg::CMD_SAVE) begin
				saved_r <= 1'b1;
			end else if (cfg_cmd == rcf_pkg::CMD_SOFT_RESET && saved_r) begin
				serial_rate_setting <= pending_rate;
				saved_r <= 1'b0;
			end
		end
	end
endmodule : rcf_dev

// *** tb/rcf_link_properties.sv ***
// rcf_link_properties: framing checks on the link between the two ends.
// assumes: one clock, sys_rst synchronous active high.
`timescale 1ns/1ps
module rcf_link_properties #(
	parameter int MAX_DATA = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// link
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic ready
);
	logic [5:0] pos_r;
	logic [15:0] len_r;
	logic [7:0] sum_r;
	logic take;
	logic last;
	assign take = valid && ready;
	// len_r unset until offset 3, so the position guard comes first
	assign last = pos_r > 6'h02 && {10'h000, pos_r} == len_r + 16'h0003;
	always_ff @(posedge core_clk) begin
		if (sys_rst || (take && last)) begin
			pos_r <= 6'h00;
		end else if (take) begin
			pos_r <= pos_r + 6'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (take && pos_r == 6'h01) begin
			len_r[15:8] <= data;
		end
		if (take && pos_r == 6'h02) begin
			len_r[7:0] <= data;
		end
	end
	always_ff @(posedge core_clk) begin
		sum_r <= (pos_r < 6'h03) ? 8'h00 : sum_r + (take ? data : 8'h00);
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_start; valid && pos_r == 6'h00 |-> data == 8'h7E; endproperty
	a_start: assert property (p_start)
		else $error("bad start byte");
	property p_len;
		valid && pos_r == 6'h02 |-> {len_r[15:8], data} >= 16'h000F &&
			{len_r[15:8], data} <= 16'h000F + 16'(MAX_DATA);
	endproperty
	a_len: assert property (p_len)
		else $error("bad length");
	property p_stream; take && !last |=> valid; endproperty
	a_stream: assert property (p_stream)
		else $error("gap inside frame");
	property p_type; valid && pos_r == 6'h03 |-> data == 8'h97; endproperty
	a_type: assert property (p_type)
		else $error("bad type byte");
	property p_id; valid && pos_r == 6'h04 |-> data != 8'h00; endproperty
	a_id: assert property (p_id)
		else $error("zero id framed");
	property p_rsv;
		valid && pos_r == 6'h0D |-> data == 8'hFF ##1 valid && data == 8'hFE;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("bad reserved bytes");
	property p_status;
		valid && pos_r == 6'h11 |-> data[7] && data[5:2] == 4'h0;
	endproperty
	a_status: assert property (p_status)
		else $error("bad status byte");
	property p_csum; valid && last |-> data == 8'hFF - sum_r; endproperty
	a_csum: assert property (p_csum)
		else $error("bad checksum");
	property p_gap; take && last |=> !valid ##1 !valid; endproperty
	a_gap: assert property (p_gap)
		else $error("frames too close");
endmodule : rcf_link_properties

// *** tb/test_remote_cmd_response_framer.sv ***
// test_remote_cmd_response_framer: both ends joined, apb and radio driven.
// assumes: rcf_pkg, rcf_link_if, rcf_dev, rcf_host compiled first.
`timescale 1ns/1ps
module test_remote_cmd_response_framer;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic rx_valid = 1'h0;
	logic rx_reachable = 1'h1;
	logic rx_rssi_bad = 1'h0;
	logic [7:0] rx_frame_id = 8'h00;
	logic [63:0] rx_src_addr = 64'h0;
	logic [63:0] rx_data = 64'h0;
	logic [15:0] rx_cmd = 16'h0000;
	logic [3:0] rx_status = 4'h0;
	logic [3:0] rx_data_len = 4'h0;
	logic cfg_we = 1'h0;
	logic cfg_apply_opt = 1'h0;
	logic [15:0] cfg_cmd = 16'h0000;
	logic [31:0] cfg_value = 32'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rate, pend, rd, req_param;
	logic pready, pslverr, perr, irq, req_valid, rx_ready;
	logic [7:0] req_frame_id, req_options;
	logic [63:0] req_dst_addr;
	logic [15:0] req_cmd;
	logic [7:0] fq[$];
	logic [7:0] eq[$];
	int error_cnt = 0;
	int check_count = 0;
	int req_cnt = 0;
	rcf_link_if link();
	rcf_dev #(.MAX_DATA(8)) u_rcf_dev(.core_clk(core_clk), .sys_rst(sys_rst),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_reachable(rx_reachable),
		.rx_frame_id(rx_frame_id), .rx_src_addr(rx_src_addr), .rx_cmd(rx_cmd),
		.rx_status(rx_status), .rx_rssi_bad(rx_rssi_bad),
		.rx_data_len(rx_data_len), .rx_data(rx_data), .cfg_we(cfg_we),
		.cfg_cmd(cfg_cmd), .cfg_value(cfg_value), .cfg_apply_opt(cfg_apply_opt),
		.serial_rate_setting(rate), .pending_rate(pend), .link(link));
	rcf_host u_rcf_host(.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.req_valid(req_valid), .req_frame_id(req_frame_id),
		.req_dst_addr(req_dst_addr), .req_options(req_options),
		.req_cmd(req_cmd), .req_param(req_param), .link(link));
	rcf_link_properties #(.MAX_DATA(8)) u_props(.core_clk(core_clk),
		.sys_rst(sys_rst), .data(link.data), .valid(link.valid),
		.ready(link.ready));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (link.valid === 1'h1 && link.ready === 1'h1) fq.push_back(link.data);
		if (req_valid === 1'h1) req_cnt++;
	end
	task automatic chk(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// waits sample at negedge so the taking edge is the next rising one
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		i = 0;
		do begin @(negedge core_clk); i++; end while (pready !== 1'h1 && i < 50);
		if (i >= 50) begin error_cnt++; results(); end
		rd = prdata;
		perr = pslverr;
		@(posedge core_clk);
		psel <= 1'h0;
		penable <= 1'h0;
		// idle edge: next setup never lands in the release time step
		@(posedge core_clk);
	endtask : apb
	task automatic reply(input logic [7:0] id, input logic reach,
		input logic [3:0] st, input logic rs, input logic [3:0] n,
		input logic [15:0] c);
		int i;
		logic ok;
		rx_valid <= 1'h1;
		rx_frame_id <= id;
		rx_reachable <= reach;
		rx_status <= st;
		rx_rssi_bad <= rs;
		rx_data_len <= n;
		rx_cmd <= c;
		rx_src_addr <= 64'h0013A200_40522BAA;
		rx_data <= 64'h40522BAA_00000000;
		i = 0;
		// ready seen at negedge stands at the next rising edge, the taking one
		do begin
			@(negedge core_clk);
			ok = (rx_ready === 1'h1);
			@(posedge core_clk);
			i++;
		end while (!ok && i < 100);
		if (!ok) begin error_cnt++; results(); end
		rx_valid <= 1'h0;
		@(posedge core_clk);
	endtask : reply
	task automatic frame_chk(input logic [7:0] id, input logic [15:0] c,
		input logic [7:0] st, input int n);
		logic [7:0] s;
		int i;
		eq = {8'h97, id, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h40, 8'h52, 8'h2B, 8'hAA};
		eq = {eq, 8'hFF, 8'hFE, c[15:8], c[7:0], st};
		for (i = 0; i < n; i++) eq.push_back(eq[i + 6]);
		s = 8'h00;
		foreach (eq[j]) s += eq[j];
		eq = {8'h7E, 8'h00, 8'(eq.size()), eq, 8'hFF - s};
		i = 0;
		while (fq.size() < eq.size() && i < 200) begin tick(1); i++; end
		if (i >= 200) error_cnt++;
		foreach (eq[j]) chk("frame byte", fq[j], eq[j]);
		fq = {};
	endtask : frame_chk
	task automatic cfg(input logic [15:0] c, input logic [31:0] v, input logic o);
		cfg_we <= 1'h1;
		cfg_cmd <= c;
		cfg_value <= v;
		cfg_apply_opt <= o;
		@(posedge core_clk);
		cfg_we <= 1'h0;
		tick(2);
	endtask : cfg
	task automatic t_request();
		apb(1'h1, rcf_pkg::REG_ADDR_HI, 32'h0013A200);
		apb(1'h1, rcf_pkg::REG_ADDR_LO, 32'h40522BAA);
		apb(1'h1, rcf_pkg::REG_CMD, {16'h0000, rcf_pkg::CMD_SERIAL_LOW});
		apb(1'h1, rcf_pkg::REG_CTRL, 32'h0001_5502);
		tick(3);
		chk("req count", req_cnt, 1);
		chk("req id", req_frame_id, 8'h55);
		chk("req dst", req_dst_addr, 64'h0013A200_40522BAA);
		chk("req opt", req_options, 8'h02);
		chk("req cmd", req_cmd, rcf_pkg::CMD_SERIAL_LOW);
		apb(1'h1, rcf_pkg::REG_ADDR_HI, 32'h0);
		apb(1'h1, rcf_pkg::REG_ADDR_LO, 32'h0000FFFF);
		apb(1'h1, rcf_pkg::REG_CTRL, 32'h0001_5600);
		tick(3);
		chk("broadcast refused", req_cnt, 1);
		$display("request test done");
	endtask : t_request
	task automatic t_reply();
		reply(8'h55, 1'h1, 4'h0, 1'h0, 4'h4, rcf_pkg::CMD_SERIAL_LOW);
		frame_chk(8'h55, rcf_pkg::CMD_SERIAL_LOW, 8'h80, 4);
		apb(1'h0, rcf_pkg::REG_RX_INFO, 32'h0);
		chk("rx info", rd, 32'h5580534C);
		apb(1'h0, rcf_pkg::REG_RX_DATA, 32'h0);
		chk("rx data", rd, 32'h40522BAA);
		apb(1'h0, rcf_pkg::REG_RX_SRC_HI, 32'h0);
		chk("rx src", rd, 32'h0013A200);
		apb(1'h0, rcf_pkg::REG_STAT, 32'h0);
		chk("stat good", rd, 32'h1);
		chk("irq set", irq, 1'h1);
		apb(1'h1, rcf_pkg::REG_MASK, 32'h1);
		tick(1);
		chk("irq masked", irq, 1'h0);
		apb(1'h1, rcf_pkg::REG_MASK, 32'h0);
		apb(1'h1, rcf_pkg::REG_STAT, 32'h1);
		apb(1'h0, rcf_pkg::REG_STAT, 32'h0);
		chk("stat clear", rd, 32'h0);
		chk("irq clear", irq, 1'h0);
		$display("reply test done");
	endtask : t_reply
	task automatic t_status();
		// one request id answered by several frames, one per status code
		for (int k = 0; k < 4; k++) begin
			reply(8'h55, 1'h1, 4'(k), k[0], 4'h0, rcf_pkg::CMD_NODE_DISC);
			frame_chk(8'h55, rcf_pkg::CMD_NODE_DISC,
				8'h80 | (k[0] ? 8'h40 : 8'h00) | 8'(k), 0);
		end
		apb(1'h0, rcf_pkg::REG_RX_INFO, 32'h0);
		chk("last info", rd, 32'h55C34E44);
		$display("status test done");
	endtask : t_status
	task automatic t_drop();
		reply(8'h00, 1'h1, 4'h0, 1'h0, 4'h0, rcf_pkg::CMD_SERIAL_LOW);
		reply(8'h66, 1'h0, 4'h0, 1'h0, 4'h0, rcf_pkg::CMD_SERIAL_LOW);
		tick(40);
		chk("no frames", fq.size(), 0);
		$display("drop test done");
	endtask : t_drop
	task automatic t_cfg();
		cfg(rcf_pkg::CMD_SERIAL_RATE, 32'h7, 1'h0);
		chk("rate pending", {pend, rate}, {32'h7, 32'h3});
		cfg(rcf_pkg::CMD_APPLY, 32'h0, 1'h0);
		chk("rate applied", rate, 32'h7);
		cfg(rcf_pkg::CMD_SERIAL_RATE, 32'h5, 1'h1);
		chk("rate option", rate, 32'h5);
		cfg(rcf_pkg::CMD_SERIAL_RATE, 32'h9, 1'h0);
		cfg(rcf_pkg::CMD_SAVE, 32'h0, 1'h0);
		chk("rate saved only", rate, 32'h5);
		cfg(rcf_pkg::CMD_SOFT_RESET, 32'h0, 1'h0);
		chk("rate after reset", rate, 32'h9);
		apb(1'h0, 8'h2C, 32'h0);
		chk("unmapped", {perr, rd}, {1'h1, 32'h0});
		$display("config test done");
	endtask : t_cfg
	initial begin
		tick(12);
		sys_rst <= 1'h0;
		tick(2);
		chk("reset rate", rate, rcf_pkg::SERIAL_RATE_RST);
		apb(1'h0, rcf_pkg::REG_CTRL, 32'h0);
		chk("reset ctrl", {irq, rd}, {1'h0, rcf_pkg::CTRL_RST});
		t_request();
		t_reply();
		t_status();
		t_drop();
		t_cfg();
		results();
	end
endmodule : test_remote_cmd_response_framer
